// File: ifs_pkg.sv
package ifs_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int NUM_BANKS = 8;
    localparam int BANKS_PER_CONV = 4;
    localparam int PIX_W = 10;
    localparam int PIX_PER_BANK = 1000;
    localparam int ROW_PAIRS = 1500;
    localparam int SYNC_LEN = 4;
    localparam int CNT_W = 16;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int CONV_NS = 8660;
    localparam int LINE_OVH_NS = 90;
    localparam int CONV_CYCLES = (CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int LINE_OVH_CYCLES = (LINE_OVH_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNTH_THRESH_MHZ = 313;
    localparam int XFER_SCALE = CONV_CYCLES * SYNTH_THRESH_MHZ;

    // ****************************************
    // register port
    // ****************************************
    localparam logic [15:0] ADDR_SHUTTER_MODE = 16'h01D1;
    localparam logic [15:0] ADDR_RUN_STATE = 16'h4019;
    localparam logic [15:0] ADDR_INTEG = 16'h0091;
    localparam logic [15:0] ADDR_FRAME_WAIT = 16'h4021;
    localparam logic [15:0] ADDR_SYNTH_MHZ = 16'h4023;
    localparam logic [15:0] ADDR_STATUS = 16'h4025;
    localparam int RW_BIT = 0;
    localparam int ADDR_BITS = 16;
    localparam int FRAME_BITS = 32;

    localparam logic [1:0] SHUTTER_GLOBAL = 2'h0;
    localparam logic [1:0] SHUTTER_ROLLING = 2'h1;
    localparam logic [15:0] RUN_STOPPED = 16'h0000;
    localparam logic [15:0] RUN_CONTINUOUS = 16'h0003;
    localparam logic [15:0] INTEG_RESET = 16'h0320;
    localparam logic [15:0] FRAME_WAIT_RESET = 16'h0001;
    localparam logic [15:0] SYNTH_MHZ_RESET = 16'h0140;

    // ****************************************
    // sync words
    // ****************************************
    localparam logic [9:0] SYNC_PRE0 = 10'h3FF;
    localparam logic [9:0] SYNC_PRE1 = 10'h000;
    localparam logic [9:0] SYNC_PRE2 = 10'h000;
    localparam logic [9:0] CODE_FRAME_BEGIN = 10'h2AC;
    localparam logic [9:0] CODE_ROW_BEGIN = 10'h200;
    localparam logic [9:0] CODE_FRAME_END = 10'h2D8;
    localparam logic [9:0] CODE_ROW_END = 10'h274;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic valid;
        logic [ADDR_BITS-1:0] addr;
        logic [15:0] data;
    } ifs_reg_wr_t;

    typedef struct packed {
        logic valid;
        logic [PIX_W-1:0] data;
    } ifs_bank_word_t;

    typedef ifs_bank_word_t [NUM_BANKS-1:0] ifs_bank_bus_t;
    typedef logic [BANKS_PER_CONV-1:0][PIX_W-1:0] ifs_pix_quad_t;

    typedef struct packed {
        logic pulse;
        logic [CNT_W-1:0] idx;
    } ifs_row_evt_t;

endpackage : ifs_pkg

// File: ifs_serial_reg_port.sv
`timescale 1ns/1ps
module ifs_serial_reg_port (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    output ifs_pkg::ifs_reg_wr_t reg_wr,
    output logic [ifs_pkg::ADDR_BITS-1:0] rd_addr,
    input wire logic [15:0] rd_data
);
    import ifs_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic sclk_s1, sclk_s2, sclk_s3;
    logic cs_s1, cs_s2;
    logic mosi_s1, mosi_s2;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end else begin
            sclk_s1 <= spi_sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cs_s1 <= spi_cs_n;
            cs_s2 <= cs_s1;
            mosi_s1 <= spi_mosi;
            mosi_s2 <= mosi_s1;
        end
    end

    logic sclk_rise, sclk_fall, active;
    assign sclk_rise = sclk_s2 & ~sclk_s3;
    assign sclk_fall = ~sclk_s2 & sclk_s3;
    assign active = ~cs_s2;

    // ****************************************
    // shift and decode
    // ****************************************
    logic [5:0] bit_cnt;
    logic [15:0] addr_sr;
    logic [15:0] data_sr;
    logic [15:0] tx_sr;
    logic is_read;
    logic load_tx;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_cnt <= '0;
            addr_sr <= '0;
            data_sr <= '0;
            is_read <= 1'b0;
            load_tx <= 1'b0;
            reg_wr <= '0;
        end else begin
            load_tx <= 1'b0;
            reg_wr.valid <= 1'b0;
            if (!active) begin
                bit_cnt <= '0;
                is_read <= 1'b0;
            end else if (sclk_rise && bit_cnt < 6'(FRAME_BITS)) begin
                bit_cnt <= bit_cnt + 6'h01;
                if (bit_cnt < 6'(ADDR_BITS)) begin
                    addr_sr <= {addr_sr[14:0], mosi_s2};
                end else begin
                    data_sr <= {data_sr[14:0], mosi_s2};
                end
                if (bit_cnt == 6'(ADDR_BITS - 1)) begin
                    is_read <= ~mosi_s2;
                    load_tx <= ~mosi_s2;
                end
                if (bit_cnt == 6'(FRAME_BITS - 1) && addr_sr[RW_BIT]) begin
                    reg_wr.valid <= 1'b1;
                    reg_wr.addr <= addr_sr;
                    reg_wr.data <= {data_sr[14:0], mosi_s2};
                end
            end
        end
    end

    assign rd_addr = addr_sr;

    // ****************************************
    // read data out, changed on falling sclk
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_sr <= '0;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso_oe <= active & is_read;
            if (load_tx) begin
                tx_sr <= rd_data;
            end else if (active && is_read && sclk_fall) begin
                spi_miso <= tx_sr[15];
                tx_sr <= {tx_sr[14:0], 1'b0};
            end
        end
    end

endmodule : ifs_serial_reg_port

// File: ifs_frame_sequencer.sv
// Overview of operation
// - register address bit 0 is the direction: even reads, odd writes
// - sync words placed at start and end of every row on all 8 banks
// - default overlapped readout: row output overlaps next row conversion
// - conversion is 8.66 us; transfer time dominates below 313 MHz synth
// - row pair period does not depend on shutter type
// - two rows always output together, four banks per converter
// - frame timing counted in row pair periods
// - frame has integration, readout and frame wait; integration overlaps them
// - long integration stretches the frame with extra blanking
// - short integration start is delayed to end at readout start
// - readout begins right after integration ends
// - readout lasts row pairs read times row pair period
// - global shutter: whole array starts and ends integration together
// - rolling shutter: equal integration per row, staggered top to bottom
// - shutter type chosen by bits 1:0 of the shutter mode register
// - capture runs while request pin held or run state written to 3
// - pin still asserted at next integration start gives one more frame
// - defaults: frame wait of one row pair, row pair period 8.75 us
// - even rows to banks 0,2,4,6; odd rows to banks 1,3,5,7
// - each bank sends both begin codes and both end codes
`timescale 1ns/1ps
module ifs_frame_sequencer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic frame_request_pin,
    input wire logic lvds_clk,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire ifs_pkg::ifs_pix_quad_t pix_even,
    input wire ifs_pkg::ifs_pix_quad_t pix_odd,
    output logic [ifs_pkg::CNT_W-1:0] pix_col,
    output logic [ifs_pkg::CNT_W-1:0] pix_row_pair,
    output ifs_pkg::ifs_bank_bus_t bank_out,
    output logic global_reset,
    output logic global_transfer,
    output ifs_pkg::ifs_row_evt_t row_reset,
    output ifs_pkg::ifs_row_evt_t row_read,
    output logic capture_active
);
    import ifs_pkg::*;

    // ****************************************
    // register port
    // ****************************************
    ifs_reg_wr_t reg_wr;
    logic [ADDR_BITS-1:0] rd_addr;
    logic [15:0] rd_data;

    ifs_serial_reg_port u_port (
        .sys_clk(sys_clk),
        .rst(rst),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .reg_wr(reg_wr),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    logic [15:0] shutter_mode_select;
    logic [15:0] run_state_control;
    logic [15:0] integration_row_pairs;
    logic [15:0] frame_wait_row_pairs;
    logic [15:0] synth_mhz;
    logic continuous_capture_state, armed, reading;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        return a[15:1] == b[15:1];
    endfunction : hit

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shutter_mode_select <= {14'h0000, SHUTTER_GLOBAL};
            run_state_control <= RUN_STOPPED;
            integration_row_pairs <= INTEG_RESET;
            frame_wait_row_pairs <= FRAME_WAIT_RESET;
            synth_mhz <= SYNTH_MHZ_RESET;
        end else if (reg_wr.valid) begin
            if (hit(reg_wr.addr, ADDR_SHUTTER_MODE)) shutter_mode_select <= reg_wr.data;
            if (hit(reg_wr.addr, ADDR_RUN_STATE)) run_state_control <= reg_wr.data;
            if (hit(reg_wr.addr, ADDR_INTEG)) integration_row_pairs <= reg_wr.data;
            if (hit(reg_wr.addr, ADDR_FRAME_WAIT)) frame_wait_row_pairs <= reg_wr.data;
            if (hit(reg_wr.addr, ADDR_SYNTH_MHZ)) synth_mhz <= reg_wr.data;
        end
    end

    always_comb begin
        rd_data = 16'h0000;
        if (hit(rd_addr, ADDR_SHUTTER_MODE)) rd_data = shutter_mode_select;
        if (hit(rd_addr, ADDR_RUN_STATE)) rd_data = run_state_control;
        if (hit(rd_addr, ADDR_INTEG)) rd_data = integration_row_pairs;
        if (hit(rd_addr, ADDR_FRAME_WAIT)) rd_data = frame_wait_row_pairs;
        if (hit(rd_addr, ADDR_SYNTH_MHZ)) rd_data = synth_mhz;
        if (hit(rd_addr, ADDR_STATUS)) rd_data = {13'h0000, reading, armed, continuous_capture_state};
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    logic trig_s1, trig_s2, lclk_s1, lclk_s2, lclk_s3;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            lclk_s1 <= 1'b0;
            lclk_s2 <= 1'b0;
            lclk_s3 <= 1'b0;
        end else begin
            trig_s1 <= frame_request_pin;
            trig_s2 <= trig_s1;
            lclk_s1 <= lvds_clk;
            lclk_s2 <= lclk_s1;
            lclk_s3 <= lclk_s2;
        end
    end

    logic lvds_tick, capture_req, rolling;
    assign lvds_tick = lclk_s2 & ~lclk_s3;
    assign capture_req = trig_s2 | (run_state_control == RUN_CONTINUOUS);
    assign rolling = shutter_mode_select[1:0] == SHUTTER_ROLLING;

    // ****************************************
    // row pair period
    // ****************************************
    logic [31:0] xfer_cycles, line_cycles;
    logic [31:0] lp_cnt;
    logic rp_tick;

    always_comb begin
        xfer_cycles = (synth_mhz == 16'h0000) ? 32'(XFER_SCALE) : 32'(XFER_SCALE) / {16'h0000, synth_mhz};
        // the slower of transfer and conversion sets the period, same for both shutters
        line_cycles = ((xfer_cycles > 32'(CONV_CYCLES)) ? xfer_cycles : 32'(CONV_CYCLES))
                      + 32'(LINE_OVH_CYCLES);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lp_cnt <= '0;
        end else if (lp_cnt >= line_cycles - 32'h1) begin
            lp_cnt <= '0;
        end else begin
            lp_cnt <= lp_cnt + 32'h1;
        end
    end
    assign rp_tick = lp_cnt >= line_cycles - 32'h1;

    // ****************************************
    // frame sequencing in row pair units
    // ****************************************
    logic [CNT_W-1:0] integ, busy_len, frame_len, start_pos, pos;
    logic [CNT_W-1:0] next_pos;
    logic next_continuous_capture_state, next_armed, next_reading, int_start, int_end;

    always_comb begin
        integ = (integration_row_pairs == 16'h0000) ? 16'h0001 : integration_row_pairs;
        busy_len = 16'(ROW_PAIRS) + frame_wait_row_pairs;
        frame_len = (integ > busy_len) ? integ : busy_len;
        start_pos = frame_len - integ;
        next_pos = pos;
        next_continuous_capture_state = continuous_capture_state;
        next_armed = armed;
        next_reading = reading;
        int_start = 1'b0;
        int_end = 1'b0;
        if (!continuous_capture_state) begin
            if (capture_req) begin
                next_continuous_capture_state = 1'b1;
                next_pos = start_pos;
                next_armed = 1'b1;
                int_start = 1'b1;
            end
        end else begin
            next_pos = (pos >= frame_len - 16'h0001) ? 16'h0000 : pos + 16'h0001;
            if (next_pos == 16'h0000) begin
                next_reading = armed;
                int_end = armed;
                next_armed = 1'b0;
            end
            if (next_pos == start_pos && capture_req) begin
                next_armed = 1'b1;
                int_start = 1'b1;
            end
            if (next_pos == 16'h0000 && !next_armed && !armed) begin
                next_continuous_capture_state = 1'b0;
                next_reading = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            continuous_capture_state <= 1'b0;
            armed <= 1'b0;
            reading <= 1'b0;
            pos <= '0;
        end else if (rp_tick) begin
            continuous_capture_state <= next_continuous_capture_state;
            armed <= next_armed;
            reading <= next_reading;
            pos <= next_pos;
        end
    end

    // ****************************************
    // shutter strobes
    // ****************************************
    logic rs_active;
    logic [CNT_W-1:0] rs_idx;
    logic read_go;
    assign read_go = rp_tick && next_reading && next_pos < 16'(ROW_PAIRS);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            global_reset <= 1'b0;
            global_transfer <= 1'b0;
            row_read <= '0;
            capture_active <= 1'b0;
        end else begin
            global_reset <= rp_tick && int_start && !rolling;
            global_transfer <= rp_tick && int_end && !rolling;
            row_read.pulse <= read_go;
            if (read_go) row_read.idx <= next_pos;
            capture_active <= rp_tick ? next_continuous_capture_state : continuous_capture_state;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rs_active <= 1'b0;
            rs_idx <= '0;
            row_reset <= '0;
        end else begin
            row_reset.pulse <= 1'b0;
            if (rp_tick && int_start && rolling) begin
                rs_active <= 1'b1;
                rs_idx <= 16'h0001;
                row_reset.pulse <= 1'b1;
                row_reset.idx <= '0;
            end else if (rp_tick && rs_active) begin
                rs_active <= rs_idx < 16'(ROW_PAIRS - 1);
                rs_idx <= rs_idx + 16'h0001;
                row_reset.pulse <= 1'b1;
                row_reset.idx <= rs_idx;
            end
        end
    end

    // ****************************************
    // output row engine
    // ****************************************
    typedef enum logic [1:0] {O_IDLE, O_HEAD, O_PIX, O_TAIL} ifs_out_state_t;
    ifs_out_state_t ostate;
    logic [CNT_W-1:0] ocnt;
    logic pend, pend_first, pend_last, row_first, row_last;
    logic [CNT_W-1:0] pend_idx;

    function automatic logic [9:0] sync_word(input logic [CNT_W-1:0] k, input logic [9:0] code);
        logic [9:0] w;
        w = code;
        if (k == 16'h0000) w = SYNC_PRE0;
        if (k == 16'h0001) w = SYNC_PRE1;
        if (k == 16'h0002) w = SYNC_PRE2;
        return w;
    endfunction : sync_word

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend <= 1'b0;
            pend_first <= 1'b0;
            pend_last <= 1'b0;
            pend_idx <= '0;
        end else if (row_read.pulse) begin
            pend <= 1'b1;
            pend_first <= row_read.idx == 16'h0000;
            pend_last <= row_read.idx == 16'(ROW_PAIRS - 1);
            pend_idx <= row_read.idx;
        end else if (lvds_tick && ostate == O_IDLE) begin
            pend <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ostate <= O_IDLE;
            ocnt <= '0;
            row_first <= 1'b0;
            row_last <= 1'b0;
            pix_row_pair <= '0;
        end else if (lvds_tick) begin
            ocnt <= ocnt + 16'h0001;
            unique case (ostate)
                O_IDLE: begin
                    ocnt <= '0;
                    if (pend) begin
                        ostate <= O_HEAD;
                        row_first <= pend_first;
                        row_last <= pend_last;
                        pix_row_pair <= pend_idx;
                    end
                end
                O_HEAD: if (ocnt == 16'(SYNC_LEN - 1)) begin
                    ostate <= O_PIX;
                    ocnt <= '0;
                end
                O_PIX: if (ocnt == 16'(PIX_PER_BANK - 1)) begin
                    ostate <= O_TAIL;
                    ocnt <= '0;
                end
                O_TAIL: if (ocnt == 16'(SYNC_LEN - 1)) begin
                    ostate <= O_IDLE;
                    ocnt <= '0;
                end
            endcase
        end
    end

    assign pix_col = ocnt;

    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++) begin : g_bank
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    bank_out[b] <= '0;
                end else begin
                    bank_out[b].valid <= lvds_tick && ostate != O_IDLE;
                    if (lvds_tick) begin
                        unique case (ostate)
                            O_IDLE: bank_out[b].data <= '0;
                            O_HEAD: bank_out[b].data <= sync_word(ocnt,
                                row_first ? CODE_FRAME_BEGIN : CODE_ROW_BEGIN);
                            O_PIX: bank_out[b].data <= (b % 2 == 0) ? pix_even[b / 2]
                                                                    : pix_odd[b / 2];
                            O_TAIL: bank_out[b].data <= sync_word(ocnt,
                                row_last ? CODE_FRAME_END : CODE_ROW_END);
                        endcase
                    end
                end
            end
        end
    endgenerate

endmodule : ifs_frame_sequencer

// File: ifs_seq_properties.sv
`timescale 1ns/1ps
module ifs_seq_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic spi_miso_oe,
    input wire ifs_pkg::ifs_bank_bus_t bank_out,
    input wire logic global_reset,
    input wire ifs_pkg::ifs_row_evt_t row_reset,
    input wire logic capture_active
);
    import ifs_pkg::*;
    // ********
    // checks
    // ********
    localparam int MIN_GAP = CONV_CYCLES + LINE_OVH_CYCLES - 1;
    logic [NUM_BANKS-1:0] vb;
    logic [15:0] gap;
    logic seen;
    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            vb[b] = bank_out[b].valid;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gap <= '0;
            seen <= 1'b0;
        end else if (row_reset.pulse) begin
            gap <= '0;
            seen <= 1'b1;
        end else if (gap != 16'hFFFF) begin
            gap <= gap + 16'h0001;
        end
    end
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    property p_gr_pulse; global_reset |=> !global_reset; endproperty
    a_gr_pulse: assert property (p_gr_pulse) else $error("long global reset");
    property p_gr_act; global_reset |-> capture_active; endproperty
    a_gr_act: assert property (p_gr_act) else $error("global reset while idle");
    property p_rr_act; row_reset.pulse |-> capture_active; endproperty
    a_rr_act: assert property (p_rr_act) else $error("row reset while idle");
    property p_banks; |vb |-> &vb; endproperty
    a_banks: assert property (p_banks) else $error("banks not in step");
    property p_vpulse; vb[0] |=> !vb[0]; endproperty
    a_vpulse: assert property (p_vpulse) else $error("valid too long");
    property p_gap; row_reset.pulse && seen |-> gap >= MIN_GAP; endproperty
    a_gap: assert property (p_gap) else $error("row pairs too close");
    property p_oe_on; $rose(spi_miso_oe) |-> !spi_cs_n; endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso driven unselected");
    property p_oe_off; $rose(spi_cs_n) |-> ##[0:4] !spi_miso_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso held after frame");
    c_gr: cover property (global_reset);
    c_rr: cover property (row_reset.pulse);
    c_act: cover property ($rose(capture_active));
endmodule : ifs_seq_properties

// File: ifs_grabber_model.sv
`timescale 1ns/1ps
module ifs_grabber_model (
    input wire logic sys_clk,
    input wire ifs_pkg::ifs_bank_bus_t bank_out,
    output logic lvds_clk,
    output int bad,
    output int rows
);
    import ifs_pkg::*;
    // ********
    // receiver
    // ********
    int n = 0;
    initial begin
        lvds_clk = 1'b0;
        bad = 0;
        rows = 0;
    end
    always #62.5 lvds_clk = ~lvds_clk;
    always @(posedge sys_clk) begin
        if (bank_out[0].valid) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                if (!bank_out[b].valid) bad++;
                if (n == 0 && bank_out[b].data !== SYNC_PRE0) bad++;
                if (n == 3 && !(bank_out[b].data inside {CODE_FRAME_BEGIN, CODE_ROW_BEGIN})) bad++;
                if (n == 1007 && !(bank_out[b].data inside {CODE_FRAME_END, CODE_ROW_END})) bad++;
            end
            if (n == 1007) rows++;
            n = (n == 1007) ? 0 : n + 1;
        end
    end
endmodule : ifs_grabber_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ifs_pkg::*;
    // ********
    // bench
    // ********
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic pin = 1'b0;
    logic sclk = 1'b0;
    logic cs_n = 1'b1;
    logic mosi = 1'b0;
    logic lvds_clk, miso, oe, gr, act;
    ifs_pix_quad_t pe = '0;
    ifs_pix_quad_t po = '0;
    ifs_bank_bus_t bank;
    ifs_row_evt_t rr;
    int errors = 0;
    int checks = 0;
    int bad, t, rows;
    int seed = 32'h171a;
    logic [15:0] q;
    logic [63:0] rnd;
    logic [15:0] ra [6] = '{ADDR_SHUTTER_MODE, ADDR_RUN_STATE, ADDR_INTEG, ADDR_FRAME_WAIT, ADDR_SYNTH_MHZ, 16'h1235};
    int m [6];
    int idx [$];
    int sy [3] = '{320, 200, 400};
    always #5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        rnd = {$random(seed), $random(seed)};
        pe = rnd[39:0];
        po = rnd[63:24];
    end
    ifs_frame_sequencer ifs_frame_sequencer_i (.sys_clk(sys_clk), .rst(rst), .frame_request_pin(pin),
        .lvds_clk(lvds_clk), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe),
        .pix_even(pe), .pix_odd(po), .pix_col(), .pix_row_pair(), .bank_out(bank), .global_reset(gr),
        .global_transfer(), .row_reset(rr), .row_read(), .capture_active(act));
    ifs_grabber_model ifs_grabber_model_i (.sys_clk(sys_clk), .bank_out(bank), .lvds_clk(lvds_clk), .bad(bad),
        .rows(rows));
    function automatic int per(input int mhz);
        return (XFER_SCALE / mhz > CONV_CYCLES ? XFER_SCALE / mhz : CONV_CYCLES) + LINE_OVH_CYCLES;
    endfunction : per
    task automatic close_out;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic spi(input logic [15:0] a, input logic [15:0] d);
        logic [31:0] w;
        w = {a, d};
        cs_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi = w[i];
            repeat (6) @(negedge sys_clk);
            if (i < 16) q[i] = miso;
            sclk = 1'b1;
            repeat (6) @(negedge sys_clk);
            sclk = 1'b0;
        end
        repeat (6) @(negedge sys_clk);
        cs_n = 1'b1;
        repeat (12) @(negedge sys_clk);
    endtask : spi
    task automatic wr(input int k, input logic [15:0] d);
        spi(ra[k], d);
        if (k < 5) m[k] = d;
    endtask : wr
    task automatic rdc(input int k);
        spi(ra[k] - 16'h0001, 16'($random(seed)));
        cmp(q, m[k]);
    endtask : rdc
    task automatic do_reset;
        rst = 1'b1;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        m = '{0, 0, INTEG_RESET, FRAME_WAIT_RESET, SYNTH_MHZ_RESET, 0};
        repeat (4) @(negedge sys_clk);
    endtask : do_reset
    task automatic wait_sig(input bit which);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(negedge sys_clk);
            if (which ? rr.pulse : gr) break;
        end
        if (i == 3000) begin
            errors++;
            close_out;
        end
        t = i;
    endtask : wait_sig
    initial begin
        do_reset;
        for (int k = 0; k < 6; k++) begin
            rdc(k);
        end
        wr(3, 16'($random(seed)) & 16'h03FF);
        wr(5, 16'h5A5A);
        wr(0, SHUTTER_ROLLING);
        for (int k = 0; k < 6; k++) begin
            rdc(k);
        end
        wr(0, SHUTTER_GLOBAL);
        repeat (2000) @(negedge sys_clk);
        cmp(act, 1'b0);
        wr(2, 16'hFFFF);
        pin = 1'b1;
        wait_sig(1'b0);
        cmp(act, 1'b1);
        pin = 1'b0;
        foreach (sy[s]) begin
            do_reset;
            wr(0, SHUTTER_ROLLING);
            wr(2, 16'hFFFF);
            wr(4, 16'(sy[s]));
            wr(1, RUN_CONTINUOUS);
            idx = {0, 1, 2, 3};
            wait_sig(1'b1);
            cmp(rr.idx, idx.pop_front());
            repeat (3) begin
                wait_sig(1'b1);
                cmp(t + 1, per(sy[s]));
                cmp(rr.idx, idx.pop_front());
            end
        end
        do_reset;
        wr(2, 16'h0001);
        wr(1, RUN_CONTINUOUS);
        for (t = 0; t < 20000 && rows == 0; t++) @(negedge sys_clk);
        cmp(32'(rows > 0), 1);
        cmp(bad, 0);
        close_out;
    end
endmodule : tb_top
bind ifs_frame_sequencer ifs_seq_properties ifs_seq_properties_i (.sys_clk(sys_clk), .rst(rst), .spi_cs_n(spi_cs_n),
    .spi_miso_oe(spi_miso_oe), .bank_out(bank_out), .global_reset(global_reset), .row_reset(row_reset),
    .capture_active(capture_active));
